/* File: tpsl_defines.svh */
// Constants for the two-phase shift register and logic cell block.
`ifndef TPSL_DEFINES_SVH
`define TPSL_DEFINES_SVH

// ----------------------------------------------------------------------
// Structure
// ----------------------------------------------------------------------
`define TPSL_STAGES       4
`define TPSL_FIFO_DEPTH   8
`define TPSL_FIFO_WIDTH   1
`define TPSL_SYNC_LEN     3
`define TPSL_PIN_PH1      0
`define TPSL_PIN_PH2      1
`define TPSL_PIN_SER      2
`define TPSL_PIN_CNT      3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TPSL_CLK_KHZ      10000
`define TPSL_MIN_RATE_KHZ 10
`define TPSL_TIMEOUT_CYC  (`TPSL_CLK_KHZ / `TPSL_MIN_RATE_KHZ)
`define TPSL_TMR_W        10

// ----------------------------------------------------------------------
// State codes
// ----------------------------------------------------------------------
`define TPSL_ST_WAIT_P1   3'h1
`define TPSL_ST_WAIT_P2   3'h2
`define TPSL_ST_LOST      3'h4

`endif

/* File: tpsl_pkg.sv */
// Types shared by the shift register and logic cell block.
`default_nettype none
`include "tpsl_defines.svh"
package tpsl_pkg;

    typedef logic [`TPSL_STAGES-1:0] tpsl_stage_t;
    typedef logic [`TPSL_TMR_W-1:0]  tpsl_tmr_t;

    typedef enum logic [2:0] {
        TPSL_WAIT_P1 = `TPSL_ST_WAIT_P1,
        TPSL_WAIT_P2 = `TPSL_ST_WAIT_P2,
        TPSL_LOST    = `TPSL_ST_LOST
    } tpsl_phase_e;

endpackage
`default_nettype wire

/* File: tpsl_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides.
`default_nettype none
`include "tpsl_defines.svh"
module tpsl_fifo
    import tpsl_pkg::*;
#(
    parameter int WIDTH = `TPSL_FIFO_WIDTH,
    parameter int DEPTH = `TPSL_FIFO_DEPTH
) (
    input  wire logic             clk,       // System clock.
    input  wire logic             rst,       // Async reset, high.
    input  wire logic             ce,        // Clock enable.
    input  wire logic             in_valid,  // Write request.
    output logic                  in_ready,  // Room for a word.
    input  wire logic [WIDTH-1:0] in_data,   // Write data.
    output logic                  out_valid, // Word available.
    input  wire logic             out_ready, // Consumer takes word.
    output logic      [WIDTH-1:0] out_data   // Head word.
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];
    logic [PW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [CW-1:0]    cnt_ff, nxt_cnt;
    logic             empty_ff, nxt_empty, full_ff, nxt_full;
    logic             push, pop;

    always_comb begin
        push    = in_valid & ~full_ff;
        pop     = out_ready & ~empty_ff;
        nxt_mem = mem_ff;
        nxt_wr  = wr_ff;
        nxt_rd  = rd_ff;
        if (push) begin
            nxt_mem[wr_ff] = in_data;
            nxt_wr = (wr_ff == PW'(DEPTH - 1)) ? '0 : wr_ff + PW'(1);
        end
        if (pop) begin
            nxt_rd = (rd_ff == PW'(DEPTH - 1)) ? '0 : rd_ff + PW'(1);
        end
        nxt_cnt   = cnt_ff + CW'(push) - CW'(pop);
        nxt_empty = (nxt_cnt == '0);
        nxt_full  = (nxt_cnt == CW'(DEPTH));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= '0;
            end
            wr_ff    <= '0;
            rd_ff    <= '0;
            cnt_ff   <= '0;
            empty_ff <= 1'h1;
            full_ff  <= 1'h0;
        end else if (ce) begin
            mem_ff   <= nxt_mem;
            wr_ff    <= nxt_wr;
            rd_ff    <= nxt_rd;
            cnt_ff   <= nxt_cnt;
            empty_ff <= nxt_empty;
            full_ff  <= nxt_full;
        end
    end

    assign in_ready  = ~full_ff;
    assign out_valid = ~empty_ff;
    assign out_data  = mem_ff[rd_ff];

endmodule // tpsl_fifo
`default_nettype wire

/* File: tpsl_cells.sv */
// Logic cells and two-phase dynamic shift register, clocked model.
`default_nettype none
`include "tpsl_defines.svh"
// Function
// - NOR output one only when all inputs zero
// - NAND output zero only when all ones
// - Active-low latch: set, clear, hold
// - Both latch inputs low drive both outputs high
// - Clocked latch acts only while gate low
// - Master captures on pulse, slave on inverse
// - JK: hold, clear, set, toggle
// - Stage takes bit on phase one, passes on two
// - Bit reaches cell output after one phase pair
// - First half inverts, second half restores
// - Half stages hold between phases
// - Content lost when phases stop
module tpsl_cells
    import tpsl_pkg::*;
(
    input  wire logic       clk,                  // System clock.
    input  wire logic       rst,                  // Async reset, high.
    input  wire logic       ce,                   // Clock enable.
    input  wire logic [2:0] nor_in,               // NOR cell inputs.
    output logic            nor_q,                // NOR cell output.
    input  wire logic [2:0] nand_in,              // NAND cell inputs.
    output logic            nand_q,               // NAND cell output.
    input  wire logic       rs_set_n,             // Latch reset, low.
    input  wire logic       rs_reset_n,           // Latch set, low.
    output logic            rs_q,                 // Latch true output.
    output logic            rs_qn,                // Latch complement.
    input  wire logic       gl_set_n,             // Gated latch reset.
    input  wire logic       gl_reset_n,           // Gated latch set.
    input  wire logic       latch_gate_n,         // Gate, acts when low.
    output logic            gl_q,                 // Gated latch true.
    output logic            gl_qn,                // Gated latch comp.
    input  wire logic       jk_j,                 // Flip-flop J.
    input  wire logic       jk_k,                 // Flip-flop K.
    input  wire logic       master_capture_pulse, // Master capture.
    output logic            jk_q,                 // Slave true output.
    output logic            jk_qn,                // Slave complement.
    input  wire logic       phase1_in,            // Shift phase one pin.
    input  wire logic       phase2_in,            // Shift phase two pin.
    input  wire logic       serial_in,            // Serial data pin.
    output logic            serial_out,           // Last stage output.
    output logic            serial_valid,         // Last stage valid.
    output logic            shift_lost,           // Phases stopped.
    output logic            fifo_in_ready,        // FIFO has room.
    output logic            out_valid,            // FIFO word ready.
    input  wire logic       out_ready,            // Consumer takes word.
    output logic            out_data              // FIFO head bit.
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [`TPSL_PIN_CNT-1:0] pin_in, lvl, rise;
    assign pin_in = {serial_in, phase2_in, phase1_in};

    for (genvar g = 0; g < `TPSL_PIN_CNT; g++) begin : g_sync
        logic [`TPSL_SYNC_LEN-1:0] sh_ff, nxt_sh;
        logic                      lvl_ff, nxt_lvl;
        always_comb begin
            nxt_sh  = {sh_ff[1:0], pin_in[g]};
            nxt_lvl = (sh_ff[1] == sh_ff[2]) ? sh_ff[2] : lvl_ff;
        end
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                sh_ff  <= '0;
                lvl_ff <= 1'h0;
            end else if (ce) begin
                sh_ff  <= nxt_sh;
                lvl_ff <= nxt_lvl;
            end
        end
        assign lvl[g]  = lvl_ff;
        assign rise[g] = nxt_lvl & ~lvl_ff;
    end

    // A phase that starts while the other is active, or together with it,
    // is ignored, so an overlapping generator cannot race data through
    // both halves.
    logic p1_ev, p2_ev;
    assign p1_ev = rise[`TPSL_PIN_PH1] & ~lvl[`TPSL_PIN_PH2]
                   & ~rise[`TPSL_PIN_PH2];
    assign p2_ev = rise[`TPSL_PIN_PH2] & ~lvl[`TPSL_PIN_PH1]
                   & ~rise[`TPSL_PIN_PH1];

    // ------------------------------------------------------------------
    // Shift stages and loss timer
    // ------------------------------------------------------------------
    tpsl_stage_t half1_ff, half2_ff, val1_ff, val2_ff;
    tpsl_stage_t nxt_half1, nxt_half2, nxt_val1, nxt_val2;
    tpsl_stage_t stage_in, val_in;
    tpsl_phase_e state_ff, nxt_state;
    tpsl_tmr_t   tmr_ff, nxt_tmr;
    logic        push_ff, nxt_push;
    logic        pair, expire;

    always_comb begin
        stage_in  = {half2_ff[`TPSL_STAGES-2:0], lvl[`TPSL_PIN_SER]};
        val_in    = {val2_ff[`TPSL_STAGES-2:0], 1'h1};
        pair      = p2_ev & (state_ff == TPSL_WAIT_P2);
        expire    = ~pair & (tmr_ff == `TPSL_TMR_W'(`TPSL_TIMEOUT_CYC - 1));
        nxt_half1 = half1_ff;
        nxt_half2 = half2_ff;
        nxt_val1  = val1_ff;
        nxt_val2  = val2_ff;
        nxt_state = state_ff;
        nxt_tmr   = tmr_ff;
        nxt_push  = p2_ev;
        if (p1_ev) begin
            nxt_half1 = ~stage_in;
            nxt_val1  = val_in;
        end
        if (p2_ev) begin
            nxt_half2 = ~half1_ff;
            nxt_val2  = val1_ff;
        end
        case (state_ff)
            TPSL_WAIT_P1: begin
                if (p1_ev) begin
                    nxt_state = TPSL_WAIT_P2;
                end
            end
            TPSL_WAIT_P2: begin
                if (pair) begin
                    nxt_state = TPSL_WAIT_P1;
                end
            end
            TPSL_LOST: begin
                if (p1_ev) begin
                    nxt_state = TPSL_WAIT_P2;
                end
            end
            default: begin
                nxt_state = TPSL_LOST;
            end
        endcase
        if (state_ff == TPSL_LOST) begin
            nxt_tmr = '0;
        end else if (pair) begin
            nxt_tmr = '0;
        end else if (expire) begin
            // Dynamic storage has leaked away: nothing held is trusted.
            nxt_state = TPSL_LOST;
            nxt_val1  = '0;
            nxt_val2  = '0;
            nxt_tmr   = '0;
        end else begin
            nxt_tmr = tmr_ff + `TPSL_TMR_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            half1_ff <= '0;
            half2_ff <= '0;
            val1_ff  <= '0;
            val2_ff  <= '0;
            state_ff <= TPSL_LOST;
            tmr_ff   <= '0;
            push_ff  <= 1'h0;
        end else if (ce) begin
            half1_ff <= nxt_half1;
            half2_ff <= nxt_half2;
            val1_ff  <= nxt_val1;
            val2_ff  <= nxt_val2;
            state_ff <= nxt_state;
            tmr_ff   <= nxt_tmr;
            push_ff  <= nxt_push;
        end
    end

    assign serial_out   = half2_ff[`TPSL_STAGES-1];
    assign serial_valid = val2_ff[`TPSL_STAGES-1];
    assign shift_lost   = (state_ff == TPSL_LOST);

    // Bits leaving the last stage are buffered; a full FIFO drops the
    // bit because a dynamic register cannot be paused without loss.
    tpsl_fifo #(
        .WIDTH (`TPSL_FIFO_WIDTH),
        .DEPTH (`TPSL_FIFO_DEPTH)
    ) tpsl_fifo_inst (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (push_ff & val2_ff[`TPSL_STAGES-1]),
        .in_ready  (fifo_in_ready),
        .in_data   (half2_ff[`TPSL_STAGES-1]),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );

    // ------------------------------------------------------------------
    // Logic cells
    // ------------------------------------------------------------------
    logic nor_ff, nand_ff, rs_st_ff, rsq_ff, rsqn_ff;
    logic gl_st_ff, glq_ff, glqn_ff, mst_ff, slv_ff, slvn_ff;
    logic nxt_nor, nxt_nand, nxt_rs_st, nxt_rsq, nxt_rsqn;
    logic nxt_gl_st, nxt_glq, nxt_glqn, nxt_mst, nxt_slv, nxt_slvn;

    always_comb begin
        nxt_nor   = ~|nor_in;
        nxt_nand  = ~&nand_in;
        nxt_rs_st = rs_st_ff;
        case ({rs_reset_n, rs_set_n})
            2'h1: nxt_rs_st = 1'h1;
            2'h2: nxt_rs_st = 1'h0;
            default: nxt_rs_st = rs_st_ff;
        endcase
        nxt_rsq   = nxt_rs_st | ~(rs_reset_n | rs_set_n);
        nxt_rsqn  = ~nxt_rs_st | ~(rs_reset_n | rs_set_n);
        nxt_gl_st = gl_st_ff;
        nxt_glq   = glq_ff;
        nxt_glqn  = glqn_ff;
        if (!latch_gate_n) begin
            case ({gl_reset_n, gl_set_n})
                2'h1: nxt_gl_st = 1'h1;
                2'h2: nxt_gl_st = 1'h0;
                default: nxt_gl_st = gl_st_ff;
            endcase
            nxt_glq  = nxt_gl_st | ~(gl_reset_n | gl_set_n);
            nxt_glqn = ~nxt_gl_st | ~(gl_reset_n | gl_set_n);
        end
        nxt_mst  = mst_ff;
        nxt_slv  = slv_ff;
        nxt_slvn = slvn_ff;
        if (master_capture_pulse) begin
            case ({jk_j, jk_k})
                2'h0: nxt_mst = slv_ff;
                2'h1: nxt_mst = 1'h0;
                2'h2: nxt_mst = 1'h1;
                default: nxt_mst = ~slv_ff;
            endcase
        end else begin
            nxt_slv  = mst_ff;
            nxt_slvn = ~mst_ff;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nor_ff   <= 1'h0;
            nand_ff  <= 1'h0;
            rs_st_ff <= 1'h0;
            rsq_ff   <= 1'h0;
            rsqn_ff  <= 1'h1;
            gl_st_ff <= 1'h0;
            glq_ff   <= 1'h0;
            glqn_ff  <= 1'h1;
            mst_ff   <= 1'h0;
            slv_ff   <= 1'h0;
            slvn_ff  <= 1'h1;
        end else if (ce) begin
            nor_ff   <= nxt_nor;
            nand_ff  <= nxt_nand;
            rs_st_ff <= nxt_rs_st;
            rsq_ff   <= nxt_rsq;
            rsqn_ff  <= nxt_rsqn;
            gl_st_ff <= nxt_gl_st;
            glq_ff   <= nxt_glq;
            glqn_ff  <= nxt_glqn;
            mst_ff   <= nxt_mst;
            slv_ff   <= nxt_slv;
            slvn_ff  <= nxt_slvn;
        end
    end

    assign nor_q  = nor_ff;
    assign nand_q = nand_ff;
    assign rs_q   = rsq_ff;
    assign rs_qn  = rsqn_ff;
    assign gl_q   = glq_ff;
    assign gl_qn  = glqn_ff;
    assign jk_q   = slv_ff;
    assign jk_qn  = slvn_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // The serial bit that the last phase one took, kept so the bit-time
    // check holds for any spacing of the two phases.
    logic ser_seen_ff, nxt_ser_seen;
    always_comb begin
        nxt_ser_seen = p1_ev ? lvl[`TPSL_PIN_SER] : ser_seen_ff;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ser_seen_ff <= 1'h0;
        end else if (ce) begin
            ser_seen_ff <= nxt_ser_seen;
        end
    end

    a_nor_output: assert property (@(posedge clk) disable iff (rst)
        !rst && ce |=> nor_q == !($past(nor_in) != 3'h0))
        else $error("NOR output wrong");
    a_nand_output: assert property (@(posedge clk) disable iff (rst)
        !rst && ce |=> nand_q == ($past(nand_in) != 3'h7))
        else $error("NAND output wrong");
    a_rs_set: assert property (@(posedge clk) disable iff (rst)
        ce && !rs_reset_n && rs_set_n ##1 ce && rs_reset_n && rs_set_n
        |=> rs_q && !rs_qn)
        else $error("Latch did not set and hold");
    a_rs_inhibit: assert property (@(posedge clk) disable iff (rst)
        ce && !rs_reset_n && !rs_set_n |=> rs_q && rs_qn)
        else $error("Latch inhibit outputs wrong");
    a_gate_hold: assert property (@(posedge clk) disable iff (rst)
        ce && latch_gate_n |=> $stable(gl_q) && $stable(gl_qn))
        else $error("Gated latch changed while gate high");
    a_jk_slave: assert property (@(posedge clk) disable iff (rst)
        ce && master_capture_pulse |=> $stable(jk_q))
        else $error("Slave moved during capture");
    a_jk_toggle: assert property (@(posedge clk) disable iff (rst)
        ce && master_capture_pulse && jk_j && jk_k
        ##1 ce && !master_capture_pulse |=> jk_q != $past(jk_q, 2))
        else $error("JK did not toggle");
    a_half_invert: assert property (@(posedge clk) disable iff (rst)
        ce && p1_ev |=> half1_ff == ~$past(stage_in))
        else $error("First half not inverted");
    a_half_hold: assert property (@(posedge clk) disable iff (rst)
        ce && !p1_ev |=> $stable(half1_ff))
        else $error("First half changed without phase one");
    a_pass_on: assert property (@(posedge clk) disable iff (rst)
        ce && p2_ev |=> half2_ff == ~$past(half1_ff))
        else $error("Second half did not take first half");
    a_one_bit: assert property (@(posedge clk) disable iff (rst)
        ce && pair |=> half2_ff[0] == ser_seen_ff)
        else $error("Bit not through cell after one pair");
    a_loss_mark: assert property (@(posedge clk) disable iff (rst)
        ce && state_ff != TPSL_LOST && expire
        |=> shift_lost && val1_ff == '0 && val2_ff == '0)
        else $error("Contents not marked invalid");
    a_no_overlap: assert property (@(posedge clk) disable iff (rst)
        (lvl[`TPSL_PIN_PH1] || rise[`TPSL_PIN_PH1])
        && (lvl[`TPSL_PIN_PH2] || rise[`TPSL_PIN_PH2])
        |-> !p1_ev && !p2_ev)
        else $error("Overlapping phase accepted");

endmodule // tpsl_cells
`default_nettype wire

/* File: tpsl_phase_gen.sv */
// Two-phase shift clock and serial data source for the cell block bench.
`default_nettype none
module tpsl_phase_gen
#(
    parameter logic [15:0] PATTERN = 16'hB2D5
) (
    input  wire logic       clk,    // Bench clock, 100 ns.
    input  wire logic       rst,    // Async reset, high.
    input  wire logic       run,    // Produce phase pairs.
    input  wire logic       slow,   // Stretch the idle gap.
    output logic            phase1, // Shift phase one.
    output logic            phase2, // Shift phase two.
    output logic            serial, // Serial data to the register.
    output logic      [7:0] pairs   // Completed phase pairs.
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------------
    // Phase one 25 cycles, gap 1, phase two 100 cycles, gap at least 10.
    // The slow period still stays well inside the retention limit.
    int   cnt;
    int   idx;
    logic active;

    assign phase1 = active && cnt < 25;
    assign phase2 = active && cnt >= 26 && cnt < 126;
    assign serial = PATTERN[idx[3:0]];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active <= 1'b0;
            cnt    <= 0;
            idx    <= 0;
            pairs  <= 8'h00;
        end else if (!active) begin
            active <= run;
            cnt    <= 0;
        end else begin
            cnt <= cnt + 1;
            if (cnt == 125) begin
                idx   <= idx + 1;
                pairs <= pairs + 8'h01;
            end
            if (cnt == (slow ? 335 : 135)) begin
                active <= run;
                cnt    <= 0;
            end
        end
    end
endmodule // tpsl_phase_gen
`default_nettype wire

/* File: tpsl_cells_tb.sv */
// Self-checking bench for the logic cells and two-phase shift register.
`default_nettype none
module tpsl_cells_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Signals and tables
    // ------------------------------------------------------------------
    localparam logic [15:0] PATTERN = 16'hB2D5;
    localparam int          LIMIT   = 10000;
    localparam logic [3:0]  RS_TAB [8] = '{4'h6, 4'hE, 4'h3, 4'hE,
                                          4'h9, 4'hD, 4'h3, 4'hD};
    localparam logic [4:0]  GL_TAB [5] = '{5'h06, 5'h1A, 5'h09, 5'h15,
                                          5'h0D};
    localparam logic [2:0]  JK_TAB [5] = '{3'h5, 3'h1, 3'h6, 3'h7, 3'h2};

    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       ce = 1'b1;
    logic       run = 1'b0;
    logic       slow = 1'b0;
    logic       out_ready = 1'b0;
    logic       mcp = 1'b0;
    logic       jk_j = 1'b0;
    logic       jk_k = 1'b0;
    logic       rs_set_n = 1'b1;
    logic       rs_reset_n = 1'b1;
    logic       gl_set_n = 1'b1;
    logic       gl_reset_n = 1'b1;
    logic       latch_gate_n = 1'b1;
    logic [2:0] nor_in = 3'h0;
    logic [2:0] nand_in = 3'h0;
    logic       nor_q, nand_q, rs_q, rs_qn, gl_q, gl_qn, jk_q, jk_qn;
    logic       phase1, phase2, serial, serial_out, serial_valid;
    logic       shift_lost, fifo_in_ready, out_valid, out_data;
    logic [7:0] pairs;
    int         fails = 0;
    int         compares = 0;
    int         cycles = 0;

    tpsl_cells tpsl_cells_inst (.clk(clk), .rst(rst), .ce(ce),
        .nor_in(nor_in), .nor_q(nor_q), .nand_in(nand_in), .nand_q(nand_q),
        .rs_set_n(rs_set_n), .rs_reset_n(rs_reset_n), .rs_q(rs_q),
        .rs_qn(rs_qn), .gl_set_n(gl_set_n), .gl_reset_n(gl_reset_n),
        .latch_gate_n(latch_gate_n), .gl_q(gl_q), .gl_qn(gl_qn),
        .jk_j(jk_j), .jk_k(jk_k), .master_capture_pulse(mcp), .jk_q(jk_q),
        .jk_qn(jk_qn), .phase1_in(phase1), .phase2_in(phase2),
        .serial_in(serial), .serial_out(serial_out),
        .serial_valid(serial_valid), .shift_lost(shift_lost),
        .fifo_in_ready(fifo_in_ready), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data));

    tpsl_phase_gen #(.PATTERN(PATTERN)) tpsl_phase_gen_inst (.clk(clk),
        .rst(rst), .run(run), .slow(slow), .phase1(phase1),
        .phase2(phase2), .serial(serial), .pairs(pairs));

    always #50 clk = ~clk;

    // The ceiling is about twice the expected run, so a hang ends early.
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic give_verdict();
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string what);
        compares++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t ns %s", $time, what);
        end
    endtask

    task automatic settle();
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic wait_pairs(input int n);
        while (pairs < n[7:0]) @(negedge clk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_gates();
        for (int v = 0; v < 8; v++) begin
            @(posedge clk);
            nor_in  <= v[2:0];
            nand_in <= v[2:0];
            settle();
            check(nor_q === ~|v[2:0], "nor output");
            check(nand_q === ~&v[2:0], "nand output");
        end
        @(posedge clk);
        ce     <= 1'b0;
        nor_in <= 3'h0;
        settle();
        check(nor_q === 1'b0, "moved with enable low");
        @(posedge clk);
        ce <= 1'b1;
        settle();
        check(nor_q === 1'b1, "nor after enable");
    endtask

    task automatic test_latches();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            rs_reset_n <= RS_TAB[i][3];
            rs_set_n   <= RS_TAB[i][2];
            settle();
            check({rs_q, rs_qn} === RS_TAB[i][1:0], "rs");
        end
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            latch_gate_n <= GL_TAB[i][4];
            gl_reset_n   <= GL_TAB[i][3];
            gl_set_n     <= GL_TAB[i][2];
            settle();
            check({gl_q, gl_qn} === GL_TAB[i][1:0], "gated latch");
        end
    endtask

    task automatic test_jk();
        logic       prev;
        logic [1:0] want;
        prev = 1'b0;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            jk_j <= JK_TAB[i][2];
            jk_k <= JK_TAB[i][1];
            mcp  <= 1'b1;
            settle();
            check(jk_q === prev, "slave moved during capture");
            @(posedge clk);
            mcp <= 1'b0;
            settle();
            want = {JK_TAB[i][0], ~JK_TAB[i][0]};
            check({jk_q, jk_qn} === want, "jk");
            prev = JK_TAB[i][0];
        end
    endtask

    task automatic test_shift();
        check(shift_lost === 1'b1, "valid after reset");
        @(posedge clk);
        run <= 1'b1;
        wait_pairs(3);
        check(out_valid === 1'b0, "bit out too early");
        wait_pairs(4);
        check(out_valid === 1'b1, "no bit after four pairs");
        check(out_data === PATTERN[0], "first bit");
        check(serial_out === PATTERN[0], "last stage bit");
        check(shift_lost === 1'b0, "lost while shifting");
        check(serial_valid === 1'b1, "last stage invalid");
        @(posedge clk);
        slow <= 1'b1;
        wait_pairs(12);
        check(fifo_in_ready === 1'b0, "buffer not full");
        @(posedge clk);
        run <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            check(out_valid === 1'b1, "data missing");
            check(out_data === PATTERN[i], "data");
            @(posedge clk);
            out_ready <= 1'b1;
            @(posedge clk);
            out_ready <= 1'b0;
            @(negedge clk);
        end
        repeat (2) @(negedge clk);
        check(out_valid === 1'b0, "buffer not empty");
        repeat (700) @(negedge clk);
        check(shift_lost === 1'b0, "lost too early");
        repeat (400) @(negedge clk);
        check(shift_lost === 1'b1, "not lost");
        check(serial_valid === 1'b0, "content kept");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(rs_qn === 1'b1 && fifo_in_ready === 1'b1, "reset values");
        test_gates();
        test_latches();
        test_jk();
        test_shift();
        give_verdict();
    end
endmodule // tpsl_cells_tb
`default_nettype wire
